// *** hw/rtm_tx_control.sv ***
// Notes on behaviour
// - carrier ratio is integer divider plus fraction over 2^21.
// - sigma-delta emits divider words averaging to programmed ratio.
// - low data selects lower FSK frequency, high selects upper.
// - deviation is word times 95 times f_xtal over 2^23, symmetric.
// - Gaussian shaping smooths FSK steps at rate from 12-bit divider.
// - controller mode switches amplifier on and off around each frame.
// - FSK amplifier power ramps impedance over ramp-duration field.
// - bypass bit feeds amplifier from unregulated battery.
// - FSK or OOK holds amplifier supply at level reference while amp is on.
// - ASK drives supply as trapezoid, ignoring level reference.
// - ASK low phase uses low level, high phase uses high level.
// - ASK ramp time is level span over f_xtal times slope rate.
// - oscillator boost is off after reset; software should enable it.
// - baud rate is f_xtal over 8 times (baud divider plus one).
// - chip rate is twice bit rate; NRZ doubles bit rate.
// - with monitors on, lock or crystal loss disables amplifier, flags it.
`timescale 1ns/1ns
`default_nettype none
module rtm_tx_control
	import rtm_pkg::*;
(
	input  wire logic               core_clk_in,        // crystal clock
	input  wire logic               resetn_in,          // async reset, low
	input  wire logic [INT_W-1:0]   carrier_integer_divider_in, // int part
	input  wire logic [FRAC_W-1:0]  carrier_fraction_word_in,   // frac part
	input  wire logic               freq_load_in,       // apply freq words
	input  wire logic [DEV_W-1:0]   freq_deviation_word_in, // FSK dev
	input  wire logic               gauss_enable_in,    // GFSK shaping
	input  wire logic [GDIV_W-1:0]  gauss_sample_divider_in, // filter rate
	input  wire logic [BAUD_DIVIDER_W-1:0] baud_divider_in,    // baud divider
	input  wire logic [1:0]         mod_select_in,      // FSK/OOK/ASK
	input  wire logic               fsm_mode_in,        // controller mode
	input  wire logic               tx_active_in,       // frame in progress
	input  wire logic               amp_enable_in,      // cpu-mode amp on
	input  wire logic [AMP_RAMP_DURATION_W-1:0] amp_ramp_duration_in, // FSK ramp time
	input  wire logic               bypass_reg_in,      // unregulated supply
	input  wire logic [LEVEL_W-1:0] amp_level_reference_in, // FSK/OOK lvl
	input  wire logic [LEVEL_W-1:0] ask_low_level_in,   // ASK low level
	input  wire logic [LEVEL_W-1:0] ask_high_level_in,  // ASK high level
	input  wire logic [SLOPE_W-1:0] ask_slope_in,       // ramp slope
	input  wire logic [RDIV_W-1:0]  ask_rate_div_in,    // ramp rate div
	input  wire logic               osc_boost_set_in,   // boost write strobe
	input  wire logic               osc_boost_value_in, // boost write value
	input  wire logic               pll_unlock_flag_in, // PLL out of lock
	input  wire logic               crystal_unstable_flag_in, // xtal fail
	input  wire logic               pll_monitor_enable_in,    // lock monitor
	input  wire logic               crystal_monitor_enable_in, // xtal mon
	input  wire logic               amp_flag_clear_in,  // clear disabled flag
	input  wire logic               mod_data_in,        // modulation chip
	input  wire logic               mod_valid_in,       // chip valid
	output logic                    mod_ready_out,      // chip accepted
	output logic [INT_W-1:0]        sd_divider_out,     // divider word
	output logic                    baud_tick_out,      // chip-rate tick
	output logic                    amp_on_out,         // amplifier enable
	output logic [AMP_RAMP_DURATION_W-1:0]      amp_impedance_out,  // FSK ramp step
	output logic [LEVEL_W-1:0]      amp_supply_pin_out, // supply DAC code
	output logic                    supply_bypass_out,  // bypass regulator
	output logic                    osc_boost_enable_out, // boost on
	output logic                    amp_disabled_flag_out // amp disabled
);
	localparam int ACC_W = FRAC_W + 2;
	localparam int DEV_FULL_W = DEV_W + 7 + 1;

	// buffered chips, consumed at chip rate
	logic                   fifo_data, fifo_valid, chip_pop;
	logic                   chip, next_chip;
	logic                   pre_tick, baud_tick, gauss_tick;
	logic [2:0]             pre_cnt, next_pre_cnt;

	rtm_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in     (core_clk_in),
		.resetn_in  (resetn_in),
		.wdata_in   (mod_data_in),
		.wvalid_in  (mod_valid_in),
		.wready_out (mod_ready_out),
		.rdata_out  (fifo_data),
		.rvalid_out (fifo_valid),
		.rready_in  (chip_pop)
	);

	// divide by 4 then by (div+1): one pulse per chip, so a bit spans
	// two chips and 8*(div+1) clocks
	always_comb begin
		pre_tick     = (pre_cnt == 3'(BAUD_PRE/CHIP_PER_BIT - 1));
		next_pre_cnt = pre_tick ? '0 : 3'(pre_cnt + 1'b1);
	end

	rtm_divider #(.WIDTH(BAUD_DIVIDER_W)) u_baud (
		.clk_in    (core_clk_in),
		.resetn_in (resetn_in),
		.run_in    (1'b1),
		.tick_in   (pre_tick),
		.div_in    (baud_divider_in),
		.pulse_out (baud_tick)
	);

	assign chip_pop = baud_tick && fifo_valid;

	// frequency words: shadow applied only on load strobe
	logic [INT_W-1:0]  int_word, next_int_word;
	logic [FRAC_W-1:0] frac_word, next_frac_word;
	always_comb begin
		next_int_word  = int_word;
		next_frac_word = frac_word;
		if (freq_load_in) begin
			next_int_word  = carrier_integer_divider_in;
			next_frac_word = carrier_fraction_word_in;
		end
		next_chip = chip_pop ? fifo_data : chip;
	end

	// gaussian-style shaping: chip level approached in GAUSS_OSR steps
	// per chip, a linear ramp approximating the smoothed step
	localparam int SH_W = 5;
	logic [SH_W-1:0] shape, next_shape;
	logic [GDIV_W-1:0] gdiv_q;
	assign gdiv_q = gauss_sample_divider_in;
	rtm_divider #(.WIDTH(GDIV_W)) u_gauss (
		.clk_in    (core_clk_in),
		.resetn_in (resetn_in),
		.run_in    (gauss_enable_in),
		// crystal rate, so (div+1) clocks per step gives 16 steps per chip
		.tick_in   (1'b1),
		.div_in    (gdiv_q),
		.pulse_out (gauss_tick)
	);
	always_comb begin
		next_shape = shape;
		if (!gauss_enable_in) begin
			next_shape = chip ? SH_W'(GAUSS_OSR) : '0;
		end else if (gauss_tick) begin
			if (chip && shape != SH_W'(GAUSS_OSR)) begin
				next_shape = SH_W'(shape + 1'b1);
			end else if (!chip && shape != '0) begin
				next_shape = SH_W'(shape - 1'b1);
			end
		end
	end

	// deviation in 2^21 units: dev*95/4, scaled by shape from -1 to +1
	logic signed [DEV_FULL_W+SH_W+1:0] dev_scaled;
	logic signed [DEV_FULL_W+SH_W+1:0] dev_used;
	logic signed [ACC_W+8:0]           ratio_frac;
	logic [ACC_W-1:0]                  acc, next_acc;
	logic [INT_W-1:0]                  next_sd;
	logic signed [ACC_W+8:0]           sum;
	always_comb begin
		dev_scaled = (DEV_FULL_W+SH_W+2)'(
			($signed({1'b0, SH_W'(shape)}) * 2 -
			$signed({1'b0, SH_W'(GAUSS_OSR)})) *
			$signed({1'b0, freq_deviation_word_in, 7'h00}) / 128 *
			DEV_MUL / (GAUSS_OSR * 4));
		// the bare '0 arm is safe: dev_used is signed, so the sum keeps the sign
		dev_used = (mod_select_in == RTM_MOD_FSK) ? dev_scaled : '0;
		ratio_frac = $signed({10'h000, frac_word}) + dev_used;
		// first-order accumulator: carry bumps divider by one
		sum = $signed({9'h000, acc}) + ratio_frac;
		next_acc = ACC_W'(sum[FRAC_W-1:0]);
		next_sd  = INT_W'($signed({1'b0, int_word}) +
			(sum >>> FRAC_W));
	end

	// amplifier enable and monitoring
	logic want_on, next_amp_on, next_flag, fault;
	logic next_boost;
	always_comb begin
		want_on = fsm_mode_in ? tx_active_in : amp_enable_in;
		fault = (pll_monitor_enable_in && pll_unlock_flag_in) ||
			(crystal_monitor_enable_in && crystal_unstable_flag_in);
		next_flag = amp_disabled_flag_out;
		if (amp_flag_clear_in) begin
			next_flag = 1'b0;
		end
		if (want_on && fault) begin
			next_flag = 1'b1;
		end
		// once tripped, amp stays off until software clears the flag
		next_amp_on = want_on && !fault && !next_flag;
		next_boost = osc_boost_set_in ? osc_boost_value_in :
			osc_boost_enable_out;
	end

	// FSK impedance ramp: one step per chip tick up to the duration
	logic [AMP_RAMP_DURATION_W-1:0] imp, next_imp;
	always_comb begin
		next_imp = imp;
		if (mod_select_in != RTM_MOD_FSK) begin
			next_imp = amp_on_out ? '1 : '0;
		end else if (baud_tick) begin
			if (amp_on_out && imp < amp_ramp_duration_in) begin
				next_imp = AMP_RAMP_DURATION_W'(imp + 1'b1);
			end else if (!amp_on_out && imp != '0) begin
				next_imp = AMP_RAMP_DURATION_W'(imp - 1'b1);
			end
		end
	end

	// ASK trapezoid: accumulator adds slope*16+rate_div+1 per clock;
	// each overflow of 16 moves the level one code
	rtm_ask_type ask_st, next_ask_st;
	logic [LEVEL_W-1:0]    level, next_level;
	logic [RAMP_ACC_W-1:0] racc, next_racc;
	logic [RAMP_ACC_W-1:0] rsum;
	logic [LEVEL_W-1:0]    steps;
	always_comb begin
		next_ask_st = ask_st;
		next_level  = level;
		next_racc   = '0;
		rsum  = RAMP_ACC_W'(racc + {ask_slope_in, 4'h0} +
			ask_rate_div_in + 1'b1);
		steps = LEVEL_W'(rsum / RDIV_FRAC);
		if (mod_select_in != RTM_MOD_ASK || !amp_on_out) begin
			next_ask_st = RTM_ASK_LOW;
			next_level  = (mod_select_in == RTM_MOD_ASK) ? LEVEL_RST :
				(amp_on_out ? amp_level_reference_in : LEVEL_RST);
		end else begin
			case (ask_st)
				RTM_ASK_LOW: begin
					next_level = ask_low_level_in;
					if (chip) begin
						next_ask_st = RTM_ASK_UP;
					end
				end
				RTM_ASK_UP: begin
					next_racc = RAMP_ACC_W'(rsum % RDIV_FRAC);
					if (32'(level) + 32'(steps) >= 32'(ask_high_level_in)) begin
						next_level  = ask_high_level_in;
						next_ask_st = RTM_ASK_HIGH;
					end else begin
						next_level = LEVEL_W'(level + steps);
					end
				end
				RTM_ASK_HIGH: begin
					next_level = ask_high_level_in;
					if (!chip) begin
						next_ask_st = RTM_ASK_DOWN;
					end
				end
				RTM_ASK_DOWN: begin
					next_racc = RAMP_ACC_W'(rsum % RDIV_FRAC);
					if (32'(level) <= 32'(ask_low_level_in) + 32'(steps)) begin
						next_level  = ask_low_level_in;
						next_ask_st = RTM_ASK_LOW;
					end else begin
						next_level = LEVEL_W'(level - steps);
					end
				end
				default: begin
					next_ask_st = RTM_ASK_LOW;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pre_cnt               <= '0;
			chip                  <= 1'b0;
			int_word              <= INT_RST;
			frac_word             <= FRAC_RST;
			shape                 <= '0;
			acc                   <= '0;
			sd_divider_out        <= INT_RST;
			baud_tick_out         <= 1'b0;
			amp_on_out            <= 1'b0;
			amp_disabled_flag_out <= 1'b0;
			osc_boost_enable_out  <= BOOST_RST;
			imp                   <= '0;
			amp_impedance_out     <= '0;
			ask_st                <= RTM_ASK_LOW;
			level                 <= LEVEL_RST;
			racc                  <= '0;
			amp_supply_pin_out    <= LEVEL_RST;
			supply_bypass_out     <= 1'b0;
		end else begin
			pre_cnt               <= next_pre_cnt;
			chip                  <= next_chip;
			int_word              <= next_int_word;
			frac_word             <= next_frac_word;
			shape                 <= next_shape;
			acc                   <= next_acc;
			sd_divider_out        <= next_sd;
			baud_tick_out         <= baud_tick;
			amp_on_out            <= next_amp_on;
			amp_disabled_flag_out <= next_flag;
			osc_boost_enable_out  <= next_boost;
			imp                   <= next_imp;
			amp_impedance_out     <= next_imp;
			ask_st                <= next_ask_st;
			level                 <= next_level;
			racc                  <= next_racc;
			amp_supply_pin_out    <= next_level;
			supply_bypass_out     <= bypass_reg_in;
		end
	end
endmodule // rtm_tx_control
`default_nettype wire

// *** common/rtm_pkg.sv ***
package rtm_pkg;
	// frequency word widths
	localparam int INT_W        = 8;
	localparam int FRAC_W       = 21;
	localparam int DEV_W        = 8;
	localparam int DEV_MUL      = 95;
	// deviation is dev*95/2^23 of f_xtal, i.e. dev*95/4 in 2^21 units
	localparam int DEV_SHIFT    = 2;
	localparam int GDIV_W       = 12;
	localparam int BAUD_DIVIDER_W      = 16;
	localparam int BAUD_PRE     = 8;
	localparam int CHIP_PER_BIT = 2;
	localparam int LEVEL_W      = 8;
	localparam int AMP_RAMP_DURATION_W      = 4;
	localparam int SLOPE_W      = 4;
	localparam int RDIV_W       = 4;
	localparam int RDIV_FRAC    = 16;
	localparam int RAMP_ACC_W   = 12;
	localparam int FIFO_DEPTH   = 16;
	localparam int GAUSS_OSR    = 16;
	// reset values
	localparam logic [INT_W-1:0]   INT_RST   = 8'h00;
	localparam logic [FRAC_W-1:0]  FRAC_RST  = 21'h000000;
	localparam logic               BOOST_RST = 1'b0;
	localparam logic [LEVEL_W-1:0] LEVEL_RST = 8'h00;
	// modulation selection
	typedef enum logic [1:0] {
		RTM_MOD_FSK = 2'b00,
		RTM_MOD_OOK = 2'b01,
		RTM_MOD_ASK = 2'b10
	} rtm_mod_type;
	// ASK supply shaping states
	typedef enum logic [1:0] {
		RTM_ASK_LOW  = 2'b00,
		RTM_ASK_UP   = 2'b01,
		RTM_ASK_HIGH = 2'b10,
		RTM_ASK_DOWN = 2'b11
	} rtm_ask_type;
endpackage

// *** hw/rtm_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtm_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,     // clock
	input  wire logic             resetn_in,  // async reset, low
	input  wire logic [WIDTH-1:0] wdata_in,   // write data
	input  wire logic             wvalid_in,  // write valid
	output logic                  wready_out, // not full
	output logic      [WIDTH-1:0] rdata_out,  // head data
	output logic                  rvalid_out, // not empty
	input  wire logic             rready_in   // pop
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr, rptr, next_wptr, next_rptr;
	logic [AW:0]      count, next_count;
	logic             push, pop;

	assign push       = wvalid_in && wready_out;
	assign pop        = rvalid_out && rready_in;
	assign wready_out = (count != (AW+1)'(DEPTH));
	assign rvalid_out = (count != '0);
	assign rdata_out  = mem[rptr];

	always_comb begin
		next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
		next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end else begin
			wptr  <= next_wptr;
			rptr  <= next_rptr;
			count <= next_count;
		end
	end

	// storage holds no reset; only entries below count are visible
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wptr] <= wdata_in;
		end
	end
endmodule // rtm_fifo
`default_nettype wire

// *** hw/rtm_divider.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtm_divider #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_in,    // clock
	input  wire logic             resetn_in, // async reset, low
	input  wire logic             run_in,    // count enable
	input  wire logic             tick_in,   // input rate enable
	input  wire logic [WIDTH-1:0] div_in,    // period minus one
	output logic                  pulse_out  // one-cycle pulse
);
	logic [WIDTH-1:0] cnt, next_cnt;
	logic             next_pulse;

	always_comb begin
		next_cnt   = cnt;
		next_pulse = 1'b0;
		if (!run_in) begin
			next_cnt = '0;
		end else if (tick_in) begin
			if (cnt >= div_in) begin
				next_cnt   = '0;
				next_pulse = 1'b1;
			end else begin
				next_cnt = WIDTH'(cnt + 1'b1);
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt       <= '0;
			pulse_out <= 1'b0;
		end else begin
			cnt       <= next_cnt;
			pulse_out <= next_pulse;
		end
	end
endmodule // rtm_divider
`default_nettype wire

// *** verification/rtm_tx_control_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtm_tx_control_assertions
	import rtm_pkg::*;
(
	input wire logic                core_clk_in,               // clock
	input wire logic                resetn_in,                 // reset
	input wire logic [INT_W-1:0]    carrier_integer_divider_in, // int
	input wire logic [FRAC_W-1:0]   carrier_fraction_word_in,  // frac
	input wire logic                freq_load_in,              // load
	input wire logic [1:0]          mod_select_in,             // mode
	input wire logic                fsm_mode_in,               // ctrl mode
	input wire logic                tx_active_in,              // frame
	input wire logic                amp_enable_in,             // cpu amp
	input wire logic                bypass_reg_in,             // bypass
	input wire logic                osc_boost_set_in,          // strobe
	input wire logic                osc_boost_value_in,        // value
	input wire logic                pll_unlock_flag_in,        // fault
	input wire logic                crystal_unstable_flag_in,  // fault
	input wire logic                pll_monitor_enable_in,     // monitor
	input wire logic                crystal_monitor_enable_in, // monitor
	input wire logic                amp_flag_clear_in,         // clear
	input wire logic [INT_W-1:0]    sd_divider_out,            // word
	input wire logic                baud_tick_out,             // tick
	input wire logic                amp_on_out,                // amp
	input wire logic                supply_bypass_out,         // bypass
	input wire logic                osc_boost_enable_out,      // boost
	input wire logic                amp_disabled_flag_out      // flag
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	logic fault;
	logic go_on;
	assign fault = (pll_monitor_enable_in && pll_unlock_flag_in)
		|| (crystal_monitor_enable_in && crystal_unstable_flag_in);
	assign go_on = (fsm_mode_in ? tx_active_in : amp_enable_in)
		&& !fault && !(amp_disabled_flag_out && !amp_flag_clear_in);
	sequence s_load_whole;
		freq_load_in && carrier_fraction_word_in == '0
			&& mod_select_in == RTM_MOD_OOK;
	endsequence
	sequence s_trip;
		(fsm_mode_in ? tx_active_in : amp_enable_in) && fault;
	endsequence
	load_whole_a: assert property (
		s_load_whole ##1 (mod_select_in == RTM_MOD_OOK && !freq_load_in)[*3]
		|-> sd_divider_out == $past(carrier_integer_divider_in, 3))
		else $error("divider word not the loaded integer");
	fault_trip_a: assert property (s_trip |=>
		amp_disabled_flag_out && !amp_on_out)
		else $error("fault did not cut the amplifier");
	flag_hold_a: assert property (
		amp_disabled_flag_out && !amp_flag_clear_in |=> amp_disabled_flag_out)
		else $error("disabled flag dropped without clear");
	amp_cpu_a: assert property (
		!fsm_mode_in |=> amp_on_out == $past(go_on))
		else $error("amplifier not following enable bit");
	amp_ctrl_a: assert property (
		fsm_mode_in |=> amp_on_out == $past(go_on))
		else $error("amplifier not following frame");
	boost_load_a: assert property (
		osc_boost_set_in |=> osc_boost_enable_out == $past(osc_boost_value_in))
		else $error("boost not loaded");
	boost_hold_a: assert property (
		!osc_boost_set_in |=> $stable(osc_boost_enable_out))
		else $error("boost changed without strobe");
	bypass_copy_a: assert property (
		$changed(bypass_reg_in) |=> supply_bypass_out == $past(bypass_reg_in))
		else $error("bypass not mirrored");
	tick_single_a: assert property (baud_tick_out |=> !baud_tick_out)
		else $error("chip tick wider than one cycle");
endmodule // rtm_tx_control_assertions
bind rtm_tx_control rtm_tx_control_assertions i_rtm_tx_control_assertions (
	.core_clk_in, .resetn_in, .carrier_integer_divider_in,
	.carrier_fraction_word_in, .freq_load_in, .mod_select_in, .fsm_mode_in,
	.tx_active_in, .amp_enable_in, .bypass_reg_in, .osc_boost_set_in,
	.osc_boost_value_in, .pll_unlock_flag_in, .crystal_unstable_flag_in,
	.pll_monitor_enable_in, .crystal_monitor_enable_in, .amp_flag_clear_in,
	.sd_divider_out, .baud_tick_out, .amp_on_out, .supply_bypass_out,
	.osc_boost_enable_out, .amp_disabled_flag_out
);
`default_nettype wire

// *** verification/rtm_chip_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtm_chip_source (
	input  wire logic clk_in,    // clock
	input  wire logic ready_in,  // chip accepted
	output logic      data_out,  // chip value
	output logic      valid_out  // chip offered
);
	initial begin
		valid_out = 1'h0;
		data_out = 1'h0;
	end
	// idle line wanders so a stale chip never looks fresh
	always @(posedge clk_in) begin
		if (!valid_out) begin
			data_out <= ~data_out;
		end
	end
	// valid stays up on return so back-to-back sends never re-raise it
	task automatic send(input logic b, input int lim, output bit ok);
		int n;
		n = 0;
		ok = 1'b0;
		valid_out = 1'h1;
		data_out = b;
		while (!ok && n < lim) begin
			@(posedge clk_in);
			ok = (ready_in === 1'h1);
			n++;
		end
		#2;
	endtask
	task automatic stop();
		valid_out = 1'h0;
	endtask
endmodule // rtm_chip_source
`default_nettype wire

// *** verification/rtm_tx_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module rtm_tx_control_tb;
	import rtm_pkg::*;
	logic core_clk_in = 1'h0;
	logic resetn_in = 1'h0;
	logic [INT_W-1:0] carrier_integer_divider_in = 8'h00;
	logic [FRAC_W-1:0] carrier_fraction_word_in = 21'h000000;
	logic [DEV_W-1:0] freq_deviation_word_in = 8'h00;
	logic [GDIV_W-1:0] gauss_sample_divider_in = 12'h000;
	logic [BAUD_DIVIDER_W-1:0] baud_divider_in = 16'h009C;
	logic [1:0] mod_select_in = 2'h1;
	logic [AMP_RAMP_DURATION_W-1:0] amp_ramp_duration_in = 4'h3;
	logic [LEVEL_W-1:0] amp_level_reference_in = 8'h5A;
	logic [LEVEL_W-1:0] ask_low_level_in = 8'h00;
	logic [LEVEL_W-1:0] ask_high_level_in = 8'h00;
	logic [SLOPE_W-1:0] ask_slope_in = 4'h1;
	logic [RDIV_W-1:0] ask_rate_div_in = 4'h3;
	logic freq_load_in = 1'h0, gauss_enable_in = 1'h0, fsm_mode_in = 1'h0;
	logic tx_active_in = 1'h0, amp_enable_in = 1'h0, bypass_reg_in = 1'h0;
	logic osc_boost_set_in = 1'h0, osc_boost_value_in = 1'h0;
	logic pll_unlock_flag_in = 1'h0, crystal_unstable_flag_in = 1'h0;
	logic pll_monitor_enable_in = 1'h0, crystal_monitor_enable_in = 1'h0;
	logic amp_flag_clear_in = 1'h0, mod_data_in, mod_valid_in, mod_ready_out;
	logic baud_tick_out, amp_on_out, supply_bypass_out, osc_boost_enable_out;
	logic amp_disabled_flag_out;
	logic [INT_W-1:0] sd_divider_out;
	logic [AMP_RAMP_DURATION_W-1:0] amp_impedance_out;
	logic [LEVEL_W-1:0] amp_supply_pin_out;
	int failures = 0, compares = 0;
	int chips[$];
	bit ok;
	always #20 core_clk_in = ~core_clk_in;
	rtm_tx_control i_rtm_tx_control (.*);
	rtm_chip_source i_rtm_chip_source (.clk_in(core_clk_in),
		.ready_in(mod_ready_out), .data_out(mod_data_in),
		.valid_out(mod_valid_in));
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#2;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic near(input string nm, input longint e,
			input logic [31:0] g, input int tol);
		compares++;
		if ((g + tol >= e && g <= e + tol) !== 1'b1) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// model pops one chip per tick, as the design's buffer does
	task automatic wait_tick(input int n, output int k);
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				cyc(1);
				k++;
			end while (baud_tick_out !== 1'h1 && k < 5000);
			if (k >= 5000) begin
				failures++;
				tally_and_finish();
			end
			if (chips.size() > 0) void'(chips.pop_front());
		end
	endtask
	task automatic push(input logic b);
		i_rtm_chip_source.send(b, 40, ok);
		i_rtm_chip_source.stop();
		if (!ok) begin
			failures++;
			tally_and_finish();
		end
		chips.push_back(b);
	endtask
	task automatic sum_words(input int n, output logic [31:0] s);
		s = 32'h0;
		repeat (n) begin
			cyc(1);
			s = s + sd_divider_out;
		end
	endtask
	initial begin
		logic [31:0] s;
		int k, n, frac, dev, bd, h;
		longint e;
		void'($urandom(32'h6D51));
		cyc(5);
		chk("boost in reset", 32'h0, osc_boost_enable_out);
		chk("ready in reset", 32'h1, mod_ready_out);
		resetn_in = 1'h1;
		cyc(1);
		osc_boost_value_in = 1'h1;
		osc_boost_set_in = 1'h1;
		cyc(1);
		osc_boost_set_in = 1'h0;
		cyc(1);
		chk("boost set", 32'h1, osc_boost_enable_out);
		$display("boost test done");
		carrier_integer_divider_in = 8'h20;
		freq_load_in = 1'h1;
		cyc(1);
		freq_load_in = 1'h0;
		cyc(4);
		chk("int word", 32'h20, sd_divider_out);
		frac = $urandom & 32'h1FFFFF;
		carrier_integer_divider_in = 8'h20;
		carrier_fraction_word_in = frac[20:0];
		freq_load_in = 1'h1;
		cyc(1);
		freq_load_in = 1'h0;
		// unloaded words must not leak into the output
		carrier_integer_divider_in = 8'h7F;
		carrier_fraction_word_in = ~frac[20:0];
		cyc(4);
		sum_words(4096, s);
		near("word sum", 32'h20000 + (frac >> 9), s, 1);
		$display("frequency test done");
		bd = 32'h9C + ($urandom % 32'h40);
		baud_divider_in = bd[15:0];
		wait_tick(2, k);
		wait_tick(1, k);
		chk("chip period", 4 * (bd + 1), k);
		$display("baud test done");
		mod_select_in = RTM_MOD_FSK;
		gauss_sample_divider_in = 12'((bd + 1) / 4 - 1);
		dev = $urandom % 32'h100;
		freq_deviation_word_in = dev[7:0];
		amp_enable_in = 1'h1;
		for (int g = 0; g < 2; g++) begin
			gauss_enable_in = g[0];
			for (int b = 1; b >= 0; b--) begin
				push(b[0]);
				wait_tick(g ? 7 : 2, k);
				sum_words(512, s);
				e = (longint'(frac) * 4 + (b ? 95 : -95) * dev) * 512;
				near("fsk sum", 32'h4000 + e / (2 ** 23), s, 2);
			end
		end
		chk("impedance end", amp_ramp_duration_in, amp_impedance_out);
		chk("fsk supply", amp_level_reference_in, amp_supply_pin_out);
		$display("fsk test done");
		mod_select_in = RTM_MOD_OOK;
		for (int m = 0; m < 2; m++) begin
			fsm_mode_in = m[0];
			bypass_reg_in = m[0];
			amp_enable_in = 1'h0;
			cyc(3);
			chk("amp idle", 32'h0, amp_on_out);
			chk("supply idle", 32'h0, amp_supply_pin_out);
			if (m) tx_active_in = 1'h1;
			else amp_enable_in = 1'h1;
			cyc(3);
			chk("amp on", 32'h1, amp_on_out);
			chk("ook supply", amp_level_reference_in, amp_supply_pin_out);
			chk("bypass", m, supply_bypass_out);
		end
		$display("amplifier test done");
		for (int f = 0; f < 3; f++) begin
			pll_monitor_enable_in = (f == 1);
			crystal_monitor_enable_in = (f == 2);
			pll_unlock_flag_in = 1'h1;
			crystal_unstable_flag_in = 1'h1;
			cyc(3);
			chk("amp in fault", f == 0, amp_on_out);
			chk("disabled flag", f != 0, amp_disabled_flag_out);
			pll_unlock_flag_in = 1'h0;
			crystal_unstable_flag_in = 1'h0;
			cyc(3);
			chk("amp latched", f == 0, amp_on_out);
			amp_flag_clear_in = 1'h1;
			cyc(1);
			amp_flag_clear_in = 1'h0;
			cyc(3);
			chk("amp back", 32'h1, amp_on_out);
		end
		$display("monitor test done");
		h = 32'h80 | ($urandom & 32'h7F);
		ask_high_level_in = h[7:0];
		mod_select_in = RTM_MOD_ASK;
		cyc(4);
		chk("ask start", ask_low_level_in, amp_supply_pin_out);
		for (int b = 1; b >= 0; b--) begin
			push(b[0]);
			n = 0;
			repeat (12 * (bd + 1)) begin
				cyc(1);
				if (amp_supply_pin_out !== ask_high_level_in
					&& amp_supply_pin_out !== ask_low_level_in) n++;
			end
			chk("ask level", b ? h : 0, amp_supply_pin_out);
			near("ask ramp", h * 4 / 5 - 1, n, 2);
		end
		$display("ask test done");
		wait_tick(1, k);
		// ask windows let the design pop chips the queue still holds
		chips.delete();
		for (int i = 0; i < 17; i++) begin
			i_rtm_chip_source.send(i[0], 3, ok);
			if (ok) chips.push_back(i & 1);
		end
		i_rtm_chip_source.stop();
		chk("fill count", 32'h10, chips.size());
		chk("ready full", 32'h0, mod_ready_out);
		wait_tick(16, k);
		cyc(8);
		chk("drain count", 32'h0, chips.size());
		chk("ready empty", 32'h1, mod_ready_out);
		$display("buffer test done");
		tally_and_finish();
	end
endmodule // rtm_tx_control_tb
`default_nettype wire
